//--- logic/msr_consts.vh
// Constants for the MAC speed control and receive frame size block
`ifndef MSR_CONSTS_VH
`define MSR_CONSTS_VH
`define MSR_OFF_CTRL      12'h100
`define MSR_OFF_RX        12'h104
`define MSR_OFF_IRQ_STAT  12'h110
`define MSR_OFF_IRQ_MASK  12'h114
`define MSR_OFF_DETECT    12'h118
`define MSR_CTRL_RST_BIT  0
`define MSR_CTRL_SPD_LO   1
`define MSR_CTRL_DPX_BIT  3
`define MSR_CTRL_ADD_BIT  4
`define MSR_CTRL_ASD_BIT  5
`define MSR_RX_EN_BIT     0
`define MSR_RX_DIS_BIT    1
`define MSR_RX_WTL_BIT    5
`define MSR_RX_MAX_LO     16
`define MSR_SPD_10        2'h0
`define MSR_SPD_100       2'h1
`define MSR_SPD_1000      2'h2
`define MSR_MAX_SIZE_RST  14'h05EE
`define MSR_WDOG_LIMIT    14'h2C00
`define MSR_WDOG_CUT      14'h2C01
`define MSR_SPD_FALLBACK  2'h0
`define MSR_DPX_FALLBACK  1'h0
`define MSR_ADD_FALLBACK  1'h1
`define MSR_ASD_FALLBACK  1'h0
`define MSR_RST_CYCLES    4'h8
`endif

//--- logic/msr_mac_ctrl.v
// MAC speed/duplex control and receive frame size enforcement
`timescale 1ns/1ps
`include "msr_consts.vh"
// What this block does
// - With auto speed detect off the speed field is written by software, else it shows the detected speed.
// - With auto duplex detect off the duplex bit is written by software, else it shows the detected duplex.
// - Speed choices are MII 10 Mbps, MII 100 Mbps and GMII 1000 Mbps.
// - Speed and duplex default from the EEPROM image, else OTP, else zero.
// - USB reset or lite soft reset restores fields to the last loaded image or fallback.
// - Auto duplex detect defaults from its boot flag, else one.
// - Auto speed detect defaults from its boot flag, else zero.
// - With truncation select clear, frames longer than the programmed maximum length plus one (bits 29:16, default 1518) are aborted.
// - With truncation select set, a watchdog cuts and aborts any frame longer than 11265 bytes.
// - With truncation select clear, cut at max plus one with oversize flag and likely CRC error.
// - With truncation select set, cut at 11265 with oversize, watchdog and likely CRC flags.
// - Clearing receive enable lets the current frame finish, then sets receiver disabled.
// - Half duplex is off whenever the speed in use is 1000 Mbps.
module msr_mac_ctrl (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Device level resets
  input  wire        usb_reset,
  input  wire        lite_soft_reset,
  // Boot image from EEPROM or OTP
  input  wire        image_valid,
  input  wire [1:0]  image_speed,
  input  wire        image_duplex,
  input  wire        boot_flag_speed_detect,
  input  wire        boot_flag_duplex_detect,
  // Detection results from the PHY side
  input  wire [1:0]  detected_speed,
  input  wire        detected_duplex,
  // Receive stream from the PHY side
  input  wire        rx_in_valid,
  input  wire        rx_in_last,
  input  wire        rx_in_crc_err,
  // Transmit enable from the transmit register
  input  wire        tx_on,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // MAC operating state
  output reg  [1:0]  mac_speed,
  output reg         mac_full_duplex,
  output reg         mac_logic_reset,
  // Receive status to the frame FIFO controller
  output reg         rx_status_valid,
  output reg  [13:0] rx_status_length,
  output reg         rx_status_long,
  output reg         rx_status_crc_err,
  output reg         watchdog_truncated_flag,
  output reg         rx_out_valid,
  // Interrupt
  output reg         irq
);

  localparam RX_IDLE = 2'h0;
  localparam RX_RECV = 2'h1;
  localparam RX_DROP = 2'h2;

  // Synchronised PHY side inputs
  reg [1:0]  spd_s1, spd_s2;
  reg        dpx_s1, dpx_s2;
  reg [2:0]  rxi_s1, rxi_s2;

  reg        auto_speed_detect, auto_duplex_detect;
  reg [1:0]  speed_select;
  reg        duplex_select;
  reg        mac_soft_reset;
  reg [3:0]  rst_cnt;
  reg        rx_on, rx_disabled, truncation_length_select;
  reg [13:0] max_size;
  reg [3:0]  irq_stat, irq_mask;
  reg [1:0]  rx_state;
  reg [13:0] rx_count;
  reg        in_frame;

  reg        aw_hold, w_hold;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  wire restore = !aresetn || usb_reset || lite_soft_reset;
  wire [1:0]  img_spd = image_valid ? image_speed : `MSR_SPD_FALLBACK;
  wire        img_dpx = image_valid ? image_duplex : `MSR_DPX_FALLBACK;
  wire        img_add = image_valid ? boot_flag_duplex_detect
                                    : `MSR_ADD_FALLBACK;
  wire        img_asd = image_valid ? boot_flag_speed_detect
                                    : `MSR_ASD_FALLBACK;

  wire        do_write = aw_hold && w_hold && !s_axi_bvalid;
  wire        do_read  = s_axi_arvalid && s_axi_arready;
  wire        wr_ctrl  = do_write && aw_addr == `MSR_OFF_CTRL;
  wire        wr_rx    = do_write && aw_addr == `MSR_OFF_RX;
  wire        wr_mask  = do_write && aw_addr == `MSR_OFF_IRQ_MASK;
  wire        rd_stat  = do_read && s_axi_araddr == `MSR_OFF_IRQ_STAT;

  wire [1:0]  eff_speed = auto_speed_detect ? spd_s2 : speed_select;
  wire        eff_dpx   = auto_duplex_detect ? dpx_s2 : duplex_select;

  wire        rx_v    = rxi_s2[0];
  wire        rx_last = rxi_s2[1];
  wire        rx_crc  = rxi_s2[2];
  wire [13:0] cut_len = truncation_length_select ? `MSR_WDOG_CUT
                        : max_size + 14'h0001;
  wire        hit_max = rx_count == max_size;
  wire        hit_wd  = rx_count == `MSR_WDOG_LIMIT;
  wire        cut_now = rx_v && !rx_last &&
                        (truncation_length_select ? hit_wd : hit_max);
  wire        frame_end = (rx_state == RX_RECV) && rx_v && (rx_last || cut_now);
  wire        start   = (rx_state == RX_IDLE) && rx_v && rx_on && !in_frame;
  reg         rx_was_on;
  reg         rx_disabled_set, rx_status_set_long, rx_status_set_wd;
  reg         rx_status_set_ok;
  wire [3:0]  events = {rx_disabled_set, rx_status_set_long,
                        rx_status_set_wd, rx_status_set_ok};

  always @* begin
    rx_disabled_set    = rx_was_on && !rx_on && rx_state == RX_IDLE;
    rx_status_set_ok   = frame_end && !cut_now;
    rx_status_set_long = frame_end && cut_now;
    rx_status_set_wd   = frame_end && cut_now && truncation_length_select;
  end

  always @(posedge aclk) begin
    spd_s1 <= detected_speed;
    spd_s2 <= spd_s1;
    dpx_s1 <= detected_duplex;
    dpx_s2 <= dpx_s1;
    rxi_s1 <= {rx_in_crc_err, rx_in_last, rx_in_valid};
    rxi_s2 <= rxi_s1;
  end

  // Control fields, restored from image on any device reset
  always @(posedge aclk) begin
    if (restore) begin
      speed_select       <= img_spd;
      duplex_select      <= img_dpx;
      auto_duplex_detect <= img_add;
      auto_speed_detect  <= img_asd;
      mac_soft_reset     <= 1'b0;
      rst_cnt            <= 4'h0;
    end else begin
      if (auto_speed_detect)
        speed_select <= spd_s2;
      else if (wr_ctrl && w_strb[0])
        speed_select <= w_data[`MSR_CTRL_SPD_LO+1:`MSR_CTRL_SPD_LO];
      if (auto_duplex_detect)
        duplex_select <= dpx_s2;
      else if (wr_ctrl && w_strb[0])
        duplex_select <= w_data[`MSR_CTRL_DPX_BIT];
      if (wr_ctrl && w_strb[0]) begin
        auto_duplex_detect <= w_data[`MSR_CTRL_ADD_BIT];
        auto_speed_detect  <= w_data[`MSR_CTRL_ASD_BIT];
      end
      if (wr_ctrl && w_strb[0] && w_data[`MSR_CTRL_RST_BIT]) begin
        mac_soft_reset <= 1'b1;
        rst_cnt        <= `MSR_RST_CYCLES;
      end else if (rst_cnt != 4'h0) begin
        rst_cnt <= rst_cnt - 4'h1;
      end else begin
        mac_soft_reset <= 1'b0;
      end
    end
  end

  // MAC state outputs
  always @(posedge aclk) begin
    if (restore) begin
      mac_speed       <= `MSR_SPD_10;
      mac_full_duplex <= 1'b0;
      mac_logic_reset <= 1'b1;
    end else begin
      // Reserved code falls back to 10 Mbps
      mac_speed <= (eff_speed == 2'h3) ? `MSR_SPD_10 : eff_speed;
      mac_full_duplex <= eff_dpx || eff_speed == `MSR_SPD_1000;
      mac_logic_reset <= mac_soft_reset;
    end
  end

  // Receive register and interrupt registers
  always @(posedge aclk) begin
    if (restore) begin
      rx_on                    <= 1'b0;
      rx_was_on                <= 1'b0;
      rx_disabled              <= 1'b0;
      truncation_length_select <= 1'b1;
      max_size                 <= `MSR_MAX_SIZE_RST;
      irq_stat                 <= 4'h0;
      irq_mask                 <= 4'h0;
      irq                      <= 1'b0;
    end else begin
      if (wr_rx && w_strb[0]) begin
        rx_on                    <= w_data[`MSR_RX_EN_BIT];
        truncation_length_select <= w_data[`MSR_RX_WTL_BIT];
      end
      if (wr_rx && w_strb[2] && w_strb[3])
        max_size <= w_data[`MSR_RX_MAX_LO+13:`MSR_RX_MAX_LO];
      if (rx_on)
        rx_was_on <= 1'b1;
      else if (rx_disabled_set)
        rx_was_on <= 1'b0;
      if (rx_disabled_set)
        rx_disabled <= 1'b1;
      else if (wr_rx && w_strb[0] && w_data[`MSR_RX_DIS_BIT])
        rx_disabled <= 1'b0;
      if (wr_mask)
        irq_mask <= w_data[3:0];
      // Set wins over the read clear
      irq_stat <= (rd_stat ? 4'h0 : irq_stat) | events;
      irq <= |(((rd_stat ? 4'h0 : irq_stat) | events) & irq_mask);
    end
  end

  // Receive frame length enforcement
  always @(posedge aclk) begin
    if (restore || mac_soft_reset) begin
      rx_state                <= RX_IDLE;
      rx_count                <= 14'h0000;
      in_frame                <= 1'b0;
      rx_out_valid            <= 1'b0;
      rx_status_valid         <= 1'b0;
      rx_status_length        <= 14'h0000;
      rx_status_long          <= 1'b0;
      rx_status_crc_err       <= 1'b0;
      watchdog_truncated_flag <= 1'b0;
    end else begin
      rx_status_valid <= 1'b0;
      rx_out_valid    <= 1'b0;
      if (rx_v)
        in_frame <= !rx_last;
      case (rx_state)
        RX_IDLE: begin
          if (start) begin
            rx_out_valid <= 1'b1;
            rx_count     <= 14'h0001;
            rx_state     <= rx_last ? RX_IDLE : RX_RECV;
          end
        end
        RX_RECV: begin
          if (rx_v) begin
            rx_out_valid <= 1'b1;
            rx_count     <= rx_count + 14'h0001;
            if (frame_end) begin
              rx_status_valid   <= 1'b1;
              rx_status_long    <= cut_now;
              rx_status_length  <= cut_now ? cut_len
                                   : rx_count + 14'h0001;
              rx_status_crc_err <= rx_crc || cut_now;
              watchdog_truncated_flag <= cut_now &&
                                         truncation_length_select;
              rx_state <= cut_now ? RX_DROP : RX_IDLE;
            end
          end
        end
        RX_DROP: begin
          if (rx_v && rx_last)
            rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // AXI4-Lite slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h00000000;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `MSR_OFF_CTRL || aw_addr == `MSR_OFF_RX ||
                         aw_addr == `MSR_OFF_IRQ_MASK ||
                         aw_addr == `MSR_OFF_IRQ_STAT ||
                         aw_addr == `MSR_OFF_DETECT) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case ({s_axi_araddr[11:2], 2'h0})
          `MSR_OFF_CTRL:
            s_axi_rdata <= {26'h0, auto_speed_detect, auto_duplex_detect,
                            duplex_select, speed_select, mac_soft_reset};
          `MSR_OFF_RX:
            s_axi_rdata <= {2'h0, max_size, 10'h000,
                            truncation_length_select, 3'h0,
                            rx_disabled, rx_on};
          `MSR_OFF_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat};
          `MSR_OFF_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
          `MSR_OFF_DETECT:   s_axi_rdata <= {29'h0, dpx_s2, spd_s2};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- test/msr_mac_ctrl_checker.sv
// Assertion checker for the speed control and frame size block
`timescale 1ns/1ps
module msr_mac_ctrl_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // MAC state
  input wire logic [1:0]  mac_speed,
  input wire logic        mac_full_duplex,
  input wire logic        mac_logic_reset,
  // Receive status
  input wire logic        rx_status_valid,
  input wire logic [13:0] rx_status_length,
  input wire logic        rx_status_long,
  input wire logic        rx_status_crc_err,
  input wire logic        watchdog_truncated_flag,
  // Bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_spd_code; mac_speed != 2'h3; endproperty
  a_spd_code: assert property (p_spd_code)
    else $error("reserved speed code in use");
  property p_gig_full; mac_speed == 2'h2 |-> mac_full_duplex; endproperty
  a_gig_full: assert property (p_gig_full)
    else $error("half duplex at gigabit speed");
  property p_wdog_len;
    rx_status_valid && watchdog_truncated_flag |->
      rx_status_length == 14'h2C01 && rx_status_long;
  endproperty
  a_wdog_len: assert property (p_wdog_len)
    else $error("watchdog cut with wrong length or flags");
  property p_long_crc; rx_status_valid && rx_status_long |-> rx_status_crc_err;
  endproperty
  a_long_crc: assert property (p_long_crc)
    else $error("cut frame without crc error");
  property p_len_cap; rx_status_valid |-> rx_status_length <= 14'h2C01;
  endproperty
  a_len_cap: assert property (p_len_cap)
    else $error("frame length beyond watchdog cut");
  property p_mac_soft_reset_ends; $rose(mac_logic_reset) |-> ##[1:16] !mac_logic_reset;
  endproperty
  a_mac_soft_reset_ends: assert property (p_mac_soft_reset_ends)
    else $error("mac reset does not clear itself");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped or changed early");
endmodule

//--- test/msr_phy_model.sv
// Line side model that sends a received frame one byte per cycle, or one byte every other cycle with gap set
`timescale 1ns/1ps
module msr_phy_model (
  // Clock and control
  input  wire logic        aclk,
  input  wire logic        start,
  input  wire logic [15:0] len,
  input  wire logic        gap,
  // Receive stream
  output logic             rx_in_valid,
  output logic             rx_in_last,
  output logic             rx_in_crc_err
);
  logic [15:0] cnt = 16'h0000;
  logic        ph  = 1'b1;
  // Slow mode leaves an idle cycle between bytes
  always @(posedge aclk) begin
    ph <= gap ? ~ph : 1'b1;
    if (start)
      cnt <= len;
    else if (rx_in_valid)
      cnt <= cnt - 16'h0001;
  end
  assign rx_in_valid   = (cnt != 16'h0000) && ph;
  assign rx_in_last    = rx_in_valid && (cnt == 16'h0001);
  assign rx_in_crc_err = 1'b0;
endmodule

//--- test/msr_mac_ctrl_bench.sv
// Self-checking bench for the speed control and frame size block
`timescale 1ns/1ps
`include "msr_consts.vh"
module msr_mac_ctrl_bench;
  reg         aclk, aresetn, usb_reset, lite_soft_reset, image_valid;
  reg         image_duplex, boot_flag_speed_detect, boot_flag_duplex_detect;
  reg  [1:0]  image_speed, detected_speed;
  reg         detected_duplex, tx_on, start, gap;
  reg  [15:0] len;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rd_data;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, st_long, st_wd;
  reg  [1:0]  rd_resp;
  reg  [13:0] st_len;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, rx_in_valid, rx_in_last, rx_in_crc_err;
  wire        mac_full_duplex, mac_logic_reset, rx_status_valid, irq;
  wire        rx_status_long, rx_status_crc_err, watchdog_truncated_flag;
  wire        rx_out_valid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, mac_speed;
  wire [31:0] s_axi_rdata;
  wire [13:0] rx_status_length;
  integer     err_count, compares, i;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  msr_mac_ctrl dut (.aclk, .aresetn, .usb_reset, .lite_soft_reset,
    .image_valid, .image_speed, .image_duplex, .boot_flag_speed_detect,
    .boot_flag_duplex_detect, .detected_speed, .detected_duplex,
    .rx_in_valid, .rx_in_last, .rx_in_crc_err, .tx_on, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mac_speed, .mac_full_duplex,
    .mac_logic_reset, .rx_status_valid, .rx_status_length, .rx_status_long,
    .rx_status_crc_err, .watchdog_truncated_flag, .rx_out_valid, .irq);
  msr_phy_model phy (.aclk, .start, .len, .gap, .rx_in_valid, .rx_in_last,
    .rx_in_crc_err);

  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    reg aw_done, w_done;
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw_done = 1'b0;
      w_done  = 1'b0;
      while (!(aw_done && w_done)) begin
        @(posedge aclk);
        if (!aw_done && s_axi_awready) begin
          aw_done = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (!w_done && s_axi_wready) begin
          w_done = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
    end
  endtask

  task rd(input [11:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  task send(input [15:0] n, input g);
    begin
      @(posedge aclk);
      len   <= n;
      gap   <= g;
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
    end
  endtask

  // Captures the status word in the cycle it is offered
  task wait_st;
    integer k;
    begin
      k = 0;
      while (!rx_status_valid && k < 12000) begin
        @(posedge aclk);
        k = k + 1;
      end
      chk({31'h0, rx_status_valid}, 32'h1);
      st_len  = rx_status_length;
      st_long = rx_status_long;
      st_wd   = watchdog_truncated_flag;
    end
  endtask

  task restore(input u);
    begin
      @(posedge aclk);
      usb_reset       <= u;
      lite_soft_reset <= !u;
      repeat (2) @(posedge aclk);
      usb_reset       <= 1'b0;
      lite_soft_reset <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask

  task finish_test;
    begin
      $display("comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  initial begin
    #200000;
    err_count = err_count + 1;
    finish_test;
  end

  initial begin
    err_count = 0;
    compares = 0;
    {aresetn, usb_reset, lite_soft_reset, image_valid, image_duplex} = 5'h00;
    {boot_flag_speed_detect, boot_flag_duplex_detect, detected_duplex} = 3'h0;
    {image_speed, detected_speed, tx_on, start, gap, len} = 23'h080000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MSR_OFF_CTRL);
    chk(rd_data, 32'h00000010);
    rd(`MSR_OFF_RX);
    chk(rd_data, 32'h05EE0020);
    $display("test reset values done");
    // Receiver and transmitter stay off while speed changes
    for (i = 0; i < 3; i = i + 1) begin
      wr(`MSR_OFF_CTRL, i * 2);
      @(posedge aclk);
      chk({30'h0, mac_speed}, i);
      chk({31'h0, mac_full_duplex}, i == 2);
      rd(`MSR_OFF_CTRL);
      chk(rd_data, i * 2);
    end
    wr(`MSR_OFF_CTRL, 32'h0000000A);
    @(posedge aclk);
    chk({31'h0, mac_full_duplex}, 32'h1);
    wr(`MSR_OFF_CTRL, 32'h00000018);
    rd(`MSR_OFF_CTRL);
    chk(rd_data, 32'h00000010);
    wr(`MSR_OFF_CTRL, 32'h00000024);
    rd(`MSR_OFF_CTRL);
    chk(rd_data, 32'h00000022);
    chk({30'h0, mac_speed}, 32'h1);
    rd(12'h0FC);
    chk({30'h0, rd_resp}, 32'h2);
    $display("test speed and duplex done");
    wr(`MSR_OFF_CTRL, 32'h00000001);
    @(posedge aclk);
    chk({31'h0, mac_logic_reset}, 32'h1);
    for (i = 0; i < 20 && mac_logic_reset; i = i + 1) @(posedge aclk);
    rd(`MSR_OFF_CTRL);
    chk(rd_data & 32'h1, 32'h0);
    $display("test mac reset done");
    wr(`MSR_OFF_IRQ_MASK, 32'h00000004);
    wr(`MSR_OFF_RX, 32'h00140001);
    send(16'd30, 1'b0);
    wait_st;
    chk({18'h0, st_len}, 32'd21);
    chk({31'h0, st_long}, 32'h1);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(`MSR_OFF_IRQ_STAT);
    chk(rd_data & 32'h4, 32'h4);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    send(16'd20, 1'b1);
    wait_st;
    chk({18'h0, st_len}, 32'd20);
    chk({31'h0, st_long}, 32'h0);
    send(16'd15, 1'b0);
    wr(`MSR_OFF_RX, 32'h00140000);
    wait_st;
    chk({18'h0, st_len}, 32'd15);
    repeat (4) @(posedge aclk);
    rd(`MSR_OFF_RX);
    chk(rd_data & 32'h3, 32'h2);
    $display("test frame size done");
    wr(`MSR_OFF_RX, 32'h05EE0020);
    wr(`MSR_OFF_RX, 32'h05EE0021);
    send(16'd11300, 1'b0);
    wait_st;
    chk({18'h0, st_len}, 32'h2C01);
    chk({31'h0, st_wd}, 32'h1);
    chk({31'h0, st_long}, 32'h1);
    wr(`MSR_OFF_RX, 32'h05EE0020);
    $display("test watchdog done");
    image_valid <= 1'b1;
    image_speed <= 2'h1;
    image_duplex <= 1'b1;
    restore(1'b0);
    rd(`MSR_OFF_CTRL);
    chk(rd_data, 32'h0000000A);
    image_speed <= 2'h2;
    boot_flag_duplex_detect <= 1'b1;
    restore(1'b1);
    rd(`MSR_OFF_CTRL);
    chk(rd_data, 32'h00000014);
    $display("test restore done");
    finish_test;
  end
endmodule

bind msr_mac_ctrl msr_mac_ctrl_checker chk_i (.aclk, .aresetn, .mac_speed,
  .mac_full_duplex, .mac_logic_reset, .rx_status_valid, .rx_status_length,
  .rx_status_long, .rx_status_crc_err, .watchdog_truncated_flag,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
